// ---- shared/acp_pkg.sv ----
`default_nettype none
package acp_pkg;
  // line buffer
  localparam int          LINE_MAX   = 64;
  localparam logic [6:0]  LINE_FULL  = 7'd64;
  // characters
  localparam logic [7:0]  CH_CR      = 8'h0d;
  localparam logic [7:0]  CH_LF      = 8'h0a;
  localparam logic [7:0]  CH_SEMI    = 8'h3b;
  localparam logic [7:0]  CH_QUERY   = 8'h3f;
  localparam logic [7:0]  CH_SPACE   = 8'h20;
  localparam logic [7:0]  CH_PLUS    = 8'h2b;
  localparam logic [7:0]  CH_MINUS   = 8'h2d;
  localparam logic [7:0]  CH_DOT     = 8'h2e;
  localparam logic [7:0]  CH_ZERO    = 8'h30;
  localparam logic [7:0]  CH_NINE    = 8'h39;
  localparam logic [7:0]  CH_LOW_A   = 8'h61;
  localparam logic [7:0]  CH_LOW_Z   = 8'h7a;
  localparam logic [7:0]  CASE_DIFF  = 8'h20;
  // command names, right aligned
  localparam logic [39:0] NM_IDENT   = 40'h2a49444e00 >> 8;
  localparam logic [39:0] NM_SETPT   = 40'h0053455449;
  localparam logic [39:0] NM_PGMSRC  = 40'h0058504701 + 40'h4c;
  localparam logic [2:0]  NAME_MAX   = 3'd5;
  // identification reply (arbitrary neutral values)
  localparam logic [6:0]  ID_LEN     = 7'd26;
  localparam logic [207:0] ID_STR    = "ACME,PS100,0000001,1.0/1.0";
  // setpoint range in units of 0.1 mA
  localparam logic [19:0] SETPT_MAX  = 20'd701000;
  localparam logic [19:0] INT_SCALE  = 20'd10000;
  localparam logic [6:0]  SETPT_LEN  = 7'd8;
  // program source values
  localparam logic [3:0]  PGM_MAX    = 4'd2;
  localparam logic [3:0]  PGM_RST    = 4'd0;
  // terminator selections
  localparam logic [1:0]  TERM_CRLF  = 2'd0;
  localparam logic [1:0]  TERM_LFCR  = 2'd1;
  localparam logic [1:0]  TERM_LF    = 2'd2;
  // parser and sequencer states
  typedef enum logic [1:0] {S_RX, S_EXEC, S_REPLY} acp_seq_t;
  typedef enum logic [1:0] {P_NAME, P_PARAM, P_BAD} acp_fld_t;
  typedef enum logic [1:0] {K_IDENT, K_SETPT, K_PGM} acp_rep_t;
endpackage : acp_pkg
`default_nettype wire

// ---- core/acp_core.sv ----
// Summary of operation
// R1 - every reply ends with configured terminators
// R2 - identity query returns maker,model,serial,firmware
// R3 - setpoint query returns signed nn.nnnn text
// R4 - program source 0 selects internal; no reply
// R5 - program source query returns one digit
// R6 - semicolon separated commands run in order
// R7 - query name without question mark: silence
// R8 - unknown names ignored, no action, no reply
// R9 - host puts space between name and parameter
// R10 - short numbers accepted, replies fixed width
// R11 - unsigned means positive, minus required negative
// R12 - host sends whole terminated lines at once
// R13 - host may space commands 100 ms apart
// R14 - asterisk prefix marks common interface command
// R15 - setpoint is nn.nnnn within 70.1000 A
// R16 - setpoint becomes ramp target, held to limit
// R17 - overlong lines dropped until next terminator
`timescale 1ns/1ps
`default_nettype none
module acp_core
  import acp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  // receive byte stream
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  output logic             rx_ready_out,
  // transmit byte stream
  output logic [7:0]       tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  // configuration
  input  wire logic [1:0]  term_sel_in,
  input  wire logic [19:0] current_limit_in,
  // instrument state
  output logic             setpoint_neg_out,
  output logic [19:0]      setpoint_mag_out,
  output logic             setpoint_load_out,
  output logic [3:0]       program_source_out,
  output logic             line_drop_out
);
  function automatic logic [23:0] acp_bcd(input logic [19:0] b);
    logic [23:0] r;
    r = '0;
    for (int i = 19; i >= 0; i--) begin
      for (int j = 0; j < 6; j++)
        if (r[4*j +: 4] >= 4'd5) r[4*j +: 4] = r[4*j +: 4] + 4'd3;
      r = {r[22:0], b[i]};
    end
    return r;
  endfunction : acp_bcd

  acp_seq_t    seq_q;
  acp_fld_t    fld_q;
  acp_rep_t    rep_q;
  logic [7:0]  line_mem [LINE_MAX];
  logic [6:0]  len_q, rd_q, ridx_q;
  logic        drop_q;
  logic [39:0] name_q;
  logic [2:0]  nlen_q, nf_q;
  logic [1:0]  ni_q;
  logic        qry_q, psome_q, sgn_q, dot_q, dig_q;
  logic [6:0]  int_q;
  logic [13:0] frac_q;
  logic [7:0]  fifo_mem [2];
  logic        fwr_q, frd_q;
  logic [1:0]  fcnt_q;

  // receive side, ready low until replies drain
  wire        rx_take  = rx_valid_in && rx_ready_out;
  wire        rx_term  = (rx_data_in == CH_CR) || (rx_data_in == CH_LF);
  wire        rx_store = rx_take && !rx_term && !drop_q && len_q != LINE_FULL;
  wire        rx_over  = rx_take && !rx_term && !drop_q && len_q == LINE_FULL;
  assign rx_ready_out = (seq_q == S_RX) && !tx_valid_out;

  // character under the parser, virtual separator after the last one
  wire        at_end  = (rd_q == len_q);
  wire [7:0]  raw_ch  = at_end ? CH_SEMI : line_mem[rd_q[5:0]];
  wire        lower   = raw_ch >= CH_LOW_A && raw_ch <= CH_LOW_Z;
  wire [7:0]  ch      = lower ? raw_ch - CASE_DIFF : raw_ch;
  wire        is_sep  = (seq_q == S_EXEC) && (ch == CH_SEMI);
  wire        is_dig  = ch >= CH_ZERO && ch <= CH_NINE;
  wire [3:0]  dval    = 4'(ch - CH_ZERO);
  wire        step    = (seq_q == S_EXEC) && !is_sep;

  // name decode
  // R14 asterisk names
  wire        nm_ident = (name_q == NM_IDENT);
  wire        nm_setpt = (name_q == NM_SETPT);
  wire        nm_pgm   = (name_q == NM_PGMSRC);
  wire        clean    = (fld_q != P_BAD);
  // R7 query needs mark
  wire        q_ok     = clean && qry_q && !psome_q;
  wire        p_ok     = clean && !qry_q && dig_q;
  // R8 unknown ignored
  wire        do_qid   = is_sep && q_ok && nm_ident;
  wire        do_qset  = is_sep && q_ok && nm_setpt;
  wire        do_qpgm  = is_sep && q_ok && nm_pgm;
  wire        pgm_ok   = ni_q == 2'd1 && !dot_q && !sgn_q
                         && int_q <= 7'(PGM_MAX);
  wire        do_pgm   = is_sep && p_ok && nm_pgm && pgm_ok;
  wire        do_set   = is_sep && p_ok && nm_setpt;
  wire        do_reply = do_qid || do_qset || do_qpgm;

  // R10 pad missing fraction digits
  wire [19:0] fscale   = (nf_q == 3'd0) ? 20'd0 :
                         (nf_q == 3'd1) ? 20'd1000 :
                         (nf_q == 3'd2) ? 20'd100 :
                         (nf_q == 3'd3) ? 20'd10 : 20'd1;
  wire [19:0] set_val  = 20'(20'(int_q) * INT_SCALE)
                         + 20'(20'(frac_q) * fscale);
  // R16 limit clamp
  wire [19:0] lim      = (current_limit_in < SETPT_MAX) ?
                         current_limit_in : SETPT_MAX;
  wire [19:0] set_clip = (set_val > lim) ? lim : set_val;

  // reply character selection
  wire [23:0] bcd      = acp_bcd(setpoint_mag_out);
  wire [6:0]  body_len = (rep_q == K_IDENT) ? ID_LEN :
                         (rep_q == K_SETPT) ? SETPT_LEN : 7'd1;
  wire [6:0]  term_len = (term_sel_in == TERM_CRLF ||
                          term_sel_in == TERM_LFCR) ? 7'd2 :
                         (term_sel_in == TERM_LF) ? 7'd1 : 7'd0;
  wire [6:0]  tidx     = ridx_q - body_len;
  wire        in_body  = ridx_q < body_len;
  wire        last_ch  = (ridx_q == body_len + term_len - 7'd1);
  wire [7:0]  id_ch    = ID_STR[8*(ID_LEN - 7'd1 - ridx_q) +: 8];
  wire [3:0]  set_dig  = (ridx_q == 7'd1) ? bcd[23:20] :
                         (ridx_q == 7'd2) ? bcd[19:16] :
                         (ridx_q == 7'd4) ? bcd[15:12] :
                         (ridx_q == 7'd5) ? bcd[11:8]  :
                         (ridx_q == 7'd6) ? bcd[7:4]   : bcd[3:0];
  // R3 sign digits point
  wire [7:0]  set_ch   = (ridx_q == 7'd0) ?
                         (setpoint_neg_out ? CH_MINUS : CH_PLUS) :
                         (ridx_q == 7'd3) ? CH_DOT : CH_ZERO + 8'(set_dig);
  // R1 trailing terminators
  wire [7:0]  term_ch  = ((term_sel_in == TERM_LFCR) == (tidx == 7'd0)) ?
                         CH_LF : CH_CR;
  wire [7:0]  fix_ch   = (term_sel_in == TERM_LF) ? CH_LF : term_ch;
  // R2 identity text, R5 one digit
  wire [7:0]  rep_ch   = !in_body ? fix_ch :
                         (rep_q == K_IDENT) ? id_ch :
                         (rep_q == K_SETPT) ? set_ch :
                         CH_ZERO + 8'(program_source_out);

  // two-entry transmit buffer
  wire        f_in_rdy = (fcnt_q != 2'd2);
  wire        f_push   = (seq_q == S_REPLY) && f_in_rdy;
  wire        f_pop    = tx_valid_out && tx_ready_in;
  assign tx_valid_out = (fcnt_q != 2'd0);
  assign tx_data_out  = fifo_mem[frd_q];

  always_ff @(posedge clk_sys_in) begin
    if (rx_store) line_mem[len_q[5:0]] <= rx_data_in;
    if (f_push) fifo_mem[fwr_q] <= rep_ch;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {fwr_q, frd_q} <= 2'h0;
      fcnt_q <= 2'd0;
    end else begin
      if (f_push) fwr_q <= ~fwr_q;
      if (f_pop) frd_q <= ~frd_q;
      fcnt_q <= 2'(fcnt_q + {1'b0, f_push} - {1'b0, f_pop});
    end
  end

  // sequencer: gather line, run it, send replies
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seq_q         <= S_RX;
      {len_q, rd_q, ridx_q} <= 21'h0;
      rep_q         <= K_IDENT;
      {drop_q, line_drop_out} <= 2'h0;
    end else begin
      line_drop_out <= rx_over;
      case (seq_q)
        S_RX: begin
          // R17 drop overlong line
          if (rx_over) begin
            drop_q <= 1'b1;
            len_q  <= 7'd0;
          end else if (rx_store) begin
            len_q <= len_q + 7'd1;
          end else if (rx_take && rx_term) begin
            drop_q <= 1'b0;
            if (!drop_q && len_q != 7'd0) begin
              seq_q <= S_EXEC;
              rd_q  <= 7'd0;
            end
          end
        end
        S_EXEC: begin
          // R6 commands in order
          rd_q <= rd_q + 7'd1;
          if (do_reply) begin
            seq_q  <= S_REPLY;
            ridx_q <= 7'd0;
            rep_q  <= do_qid ? K_IDENT : (do_qset ? K_SETPT : K_PGM);
          end else if (is_sep && at_end) begin
            seq_q <= S_RX;
            len_q <= 7'd0;
          end
        end
        S_REPLY: begin
          if (f_push) begin
            ridx_q <= ridx_q + 7'd1;
            if (last_ch) seq_q <= (rd_q > len_q) ? S_RX : S_EXEC;
            if (last_ch && rd_q > len_q) len_q <= 7'd0;
          end
        end
        default: seq_q <= S_RX;
      endcase
    end
  end

  // field parser
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fld_q   <= P_NAME;
      name_q  <= 40'h0;
      {nlen_q, nf_q} <= 6'h0;
      {qry_q, psome_q, sgn_q, dot_q, dig_q} <= 5'h0;
      {int_q, ni_q, frac_q} <= 23'h0;
    end else if (is_sep) begin
      fld_q   <= P_NAME;
      name_q  <= 40'h0;
      {nlen_q, nf_q} <= 6'h0;
      {qry_q, psome_q, sgn_q, dot_q, dig_q} <= 5'h0;
      {int_q, ni_q, frac_q} <= 23'h0;
    end else if (step) begin
      case (fld_q)
        P_NAME: begin
          // R9 space ends name
          if (ch == CH_SPACE) begin
            if (nlen_q != 3'd0) fld_q <= P_PARAM;
          end else if (ch == CH_QUERY && !qry_q && nlen_q != 3'd0) begin
            qry_q <= 1'b1;
          end else if (qry_q || nlen_q == NAME_MAX) begin
            fld_q <= P_BAD;
          end else begin
            name_q <= {name_q[31:0], ch};
            nlen_q <= nlen_q + 3'd1;
          end
        end
        P_PARAM: begin
          if (ch != CH_SPACE) psome_q <= 1'b1;
          // R11 optional plus, minus
          if (ch == CH_SPACE && !psome_q) begin
            fld_q <= P_PARAM;
          end else if ((ch == CH_PLUS || ch == CH_MINUS) && !psome_q) begin
            sgn_q <= (ch == CH_MINUS);
          end else if (ch == CH_DOT && !dot_q) begin
            dot_q <= 1'b1;
          end else if (is_dig && !dot_q && ni_q != 2'd2) begin
            // R15 two integer digits
            int_q <= 7'(int_q * 7'd10 + {3'd0, dval});
            ni_q  <= ni_q + 2'd1;
            dig_q <= 1'b1;
          end else if (is_dig && dot_q && nf_q != 3'd4) begin
            // R15 four fraction digits
            frac_q <= 14'(frac_q * 14'd10 + {10'd0, dval});
            nf_q   <= nf_q + 3'd1;
            dig_q  <= 1'b1;
          end else begin
            fld_q <= P_BAD;
          end
        end
        P_BAD:   fld_q <= P_BAD;
        default: fld_q <= P_BAD;
      endcase
    end
  end

  // instrument settings
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {setpoint_neg_out, setpoint_load_out} <= 2'h0;
      setpoint_mag_out   <= 20'd0;
      program_source_out <= PGM_RST;
    end else begin
      setpoint_load_out <= do_set;
      // R16 new ramp target
      if (do_set) begin
        setpoint_mag_out <= set_clip;
        setpoint_neg_out <= sgn_q && set_clip != 20'd0;
      end
      // R4 program source set
      if (do_pgm) program_source_out <= int_q[3:0];
    end
  end
endmodule : acp_core
`default_nettype wire

// ---- tb/acp_core_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module acp_core_checker
  import acp_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        arst_n_in,
  // watched ports
  input wire logic        rx_ready_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_valid_out,
  input wire logic        tx_ready_in,
  input wire logic [19:0] current_limit_in,
  input wire logic        setpoint_neg_out,
  input wire logic [19:0] setpoint_mag_out,
  input wire logic        setpoint_load_out,
  input wire logic [3:0]  program_source_out,
  input wire logic        line_drop_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_hold; tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out); endproperty
  a_hold: assert property (p_hold) else $error("reply not held");
  property p_txrx; tx_valid_out |-> !rx_ready_out; endproperty
  a_txrx: assert property (p_txrx) else $error("ready while reply");
  property p_drop; line_drop_out |=> !line_drop_out; endproperty
  a_drop: assert property (p_drop) else $error("drop too long");
  property p_load; setpoint_load_out |=> !setpoint_load_out; endproperty
  a_load: assert property (p_load) else $error("load too long");
  property p_lim; $changed(setpoint_mag_out) |->
    setpoint_mag_out <= current_limit_in; endproperty
  a_lim: assert property (p_lim) else $error("setpoint over limit");
  property p_max; setpoint_mag_out <= SETPT_MAX; endproperty
  a_max: assert property (p_max) else $error("setpoint over range");
  property p_negz; setpoint_neg_out |-> setpoint_mag_out != 20'h0; endproperty
  a_negz: assert property (p_negz) else $error("negative zero");
  property p_pgm; program_source_out <= PGM_MAX; endproperty
  a_pgm: assert property (p_pgm) else $error("source out of range");
endmodule : acp_core_checker
bind acp_core acp_core_checker u_chk (.clk_sys_in, .arst_n_in, .rx_ready_out,
  .tx_data_out, .tx_valid_out, .tx_ready_in, .current_limit_in,
  .setpoint_neg_out, .setpoint_mag_out, .setpoint_load_out,
  .program_source_out, .line_drop_out);
`default_nettype wire

// ---- tb/acp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module acp_host #(
  parameter int GAP = 4
) (
  // clock
  input  wire logic       clk_sys_in,
  // to core receive side
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  // from core transmit side
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  logic [7:0] got_q[$];
  int         stall = 0;
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // collect reply, stall at random
  always @(posedge clk_sys_in) begin
    if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
    tx_ready_out <= ($urandom_range(3) >= stall);
  end
  task automatic send_line(input string s);
    string t;
    t = {s, "\r\n"};
    @(posedge clk_sys_in);
    for (int i = 0; i < t.len(); i++) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= t[i];
      do @(posedge clk_sys_in); while (!rx_ready_in);
    end
    rx_valid_out <= 1'b0;
    rx_data_out <= ~t[t.len() - 1];
    repeat (GAP) @(posedge clk_sys_in);
  endtask : send_line
endmodule : acp_host
`default_nettype wire

// ---- tb/acp_core_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module acp_core_test;
  import acp_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [7:0]  rx_data, tx_data;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, neg, load, drop;
  logic [1:0]  term_sel_in = 2'h0;
  logic [19:0] current_limit_in = SETPT_MAX;
  logic [19:0] mag;
  logic [3:0]  pgm;
  int          failures = 0, checks = 0, cyc = 0, drops = 0, m, e, st;
  int          loads = 0;
  string       cn, pn, ov;
  always #2 clk_sys_in = ~clk_sys_in;
  acp_core dut (.clk_sys_in, .arst_n_in, .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .tx_data_out(tx_data),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .term_sel_in,
    .current_limit_in, .setpoint_neg_out(neg), .setpoint_mag_out(mag),
    .setpoint_load_out(load), .program_source_out(pgm), .line_drop_out(drop));
  acp_host host (.clk_sys_in, .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .rx_ready_in(rx_ready), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready));
  task close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  always @(posedge clk_sys_in) begin
    cyc++;
    if (drop === 1'b1) drops++;
    if (load === 1'b1) loads++;
    if (cyc == 60000) begin
      failures++;
      close_out();
    end
  end
  function automatic string term(input logic [1:0] s);
    if (s == 2'h0) return "\r\n";
    if (s == 2'h1) return "\n\r";
    if (s == 2'h2) return "\n";
    return "";
  endfunction : term
  function automatic string full(input logic n, input int v);
    return $sformatf("%s%02d.%04d", n ? "-" : "+", v / 10000, v % 10000);
  endfunction : full
  function automatic string brief(input int s, input int v);
    string f, r;
    f = $sformatf("%04d", v % 10000);
    while (f.len() > 0 && f[f.len() - 1] == "0")
      f = f.substr(0, f.len() - 2);
    r = $sformatf("%s%0d", (s == 1) ? "+" : "-", v / 10000);
    if (s == 0) r = r.substr(1, r.len() - 1);
    if (f.len() > 0) r = {r, ".", f};
    return r;
  endfunction : brief
  task automatic run(input string c, input string x);
    host.send_line(c);
    `CHK("reply len", x.len(), host.got_q.size())
    for (int i = 0; i < x.len() && i < host.got_q.size(); i++)
      `CHK("reply byte", x[i], host.got_q[i])
    host.got_q.delete();
  endtask : run
  initial begin
    void'($urandom(88159));
    cn = $sformatf("%s", 32'h53455449);
    pn = $sformatf("%s", 32'h5850474d);
    ov = "";
    repeat (70) ov = {ov, "A"};
    repeat (10) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    run("*IDN?", {$sformatf("%s", ID_STR), "\r\n"});
    run("*IDX?", "");
    run("IDN?", "");
    run({pn, " 1;", pn, "?"}, "1\r\n");
    run(pn, "");
    run({pn.substr(0, 2), "Q?"}, "");
    `CHK("source", 4'h1, pgm)
    run({pn, " 0"}, "");
    `CHK("source", 4'h0, pgm)
    run({pn, "?"}, "0\r\n");
    $display("test commands done");
    run(ov, "");
    `CHK("drops", 1, drops)
    run({pn, "?"}, "0\r\n");
    $display("test overflow done");
    for (int i = 0; i < 24; i++) begin
      m = (i == 0) ? 701000 : (i == 1) ? 0 : $urandom_range(701000);
      st = (i == 1) ? 2 : $urandom_range(2);
      e = (i == 0) ? 800000 : $urandom_range(800000, 1);
      @(posedge clk_sys_in);
      term_sel_in <= 2'(i);
      current_limit_in <= 20'(e);
      host.stall = i % 4;
      if (m < e) e = m;
      run({cn, " ", brief(st, m)}, "");
      `CHK("magnitude", 20'(e), mag)
      `CHK("sign", st == 2 && e != 0, neg)
      run({cn, "?"}, {full(st == 2 && e != 0, e), term(2'(i))});
    end
    `CHK("loads", 24, loads)
    $display("test setpoint done");
    run({pn, " 2"}, "");
    arst_n_in <= 1'b0;
    term_sel_in <= 2'h0;
    repeat (3) @(posedge clk_sys_in);
    `CHK("source reset", 4'h0, pgm)
    `CHK("magnitude reset", 20'h0, mag)
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    run({pn, "?"}, "0\r\n");
    $display("test reset done");
    close_out();
  end
endmodule : acp_core_test
`default_nettype wire
